// >>> sram_pkg.sv
// Shared constants and carrier types for the synchronous burst static RAM port
// Overview of operation
// [R1] Address, write data and read/write controls are sampled only on rising sys_clk.
// [R2] Sleep request and output drive enable act asynchronously, not on a clock edge; the code sets sleep_active only on an enabled edge.
// [R3] Output drive enable high kills data drivers at once, overriding clocked control.
// [R4] Writes start on a clock edge; the array write is self-timed internally.
// [R5] Pipelined reads park data in an output register, driven at the next edge.
// [R6] A configuration input selects pipelined or flow-through operation.
// [R7] Reads and writes follow back to back with no idle or deselect cycle.
// [R8] Write data trails its address by two cycles pipelined, one flow-through.
// [R9] Burst order select picks linear or interleaved burst address sequencing.
// [R10] The host holds burst order select at a fixed level during operation.
// [R11] Four 9-bit byte lanes each have a write strobe; only strobed lanes change.
// [R12] A cycle is accepted only when all three chip selects are active; the code takes burst steps regardless of them.
// [R13] Sleep request puts the device into a low-power state.
// [R14] Chip selects one and three are active low; chip select two is active high.
// [R15] Burst step high advances the burst counter instead of loading a new address.
// [R16] Clock gate is active low; edges count only while it is low.
// [R17] Write strobe low at cycle start means write; high means read.
// [R18] With clock gate high, registered state, counter and output data hold.
package sram_pkg;

  localparam int ADDR_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = LANE_W * LANES;
  localparam int BURST_W = 2;

  localparam logic BURST_LINEAR = 1'h0;
  localparam logic BURST_INTERLEAVE = 1'h1;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [LANES-1:0] lane_we;
    logic [ADDR_W-1:0] addr;
  } cmd_s;

  localparam cmd_s CMD_IDLE = '0;

endpackage : sram_pkg

// >>> sram_array.sv
// Storage array with per-lane write enables and combinational read
`timescale 1ns/1ns
module sram_array #(
  parameter int ADDR_W = 18,
  parameter int LANE_W = 9,
  parameter int LANES = 4
) (
  input wire logic sys_clk,
  input wire logic clk_ok,
  input wire logic wr_en,
  input wire logic [LANES-1:0] lane_we,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LANE_W*LANES-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [LANE_W*LANES-1:0] rd_data
);

  // No reset on the array: contents are undefined until written
  // One memory per lane keeps each lane's write process the only driver
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

    assign rd_data[g*LANE_W +: LANE_W] = mem[rd_addr];

    always_ff @(posedge sys_clk)
    begin
      if (clk_ok && wr_en && lane_we[g]) // [R4] [R11]
      begin
        mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
      end
    end
  end

endmodule : sram_array

// >>> sync_burst_sram_port.sv
// Top of the synchronous burst static RAM port: command pipeline, burst counter, data path
`timescale 1ns/1ns
module sync_burst_sram_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_gate_n,
  input wire logic [sram_pkg::ADDR_W-1:0] addr,
  input wire logic write_n,
  input wire logic lane_store_a_n,
  input wire logic lane_store_b_n,
  input wire logic lane_store_c_n,
  input wire logic lane_store_d_n,
  input wire logic chip_select_low_1,
  input wire logic chip_select_high,
  input wire logic chip_select_low_3,
  input wire logic burst_step,
  input wire logic burst_order_select,
  input wire logic flow_through_select,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic [sram_pkg::DATA_W-1:0] dq_in,
  output logic [sram_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic sleep_active
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic ce;
  logic selected;
  logic oe_kill;
  sram_pkg::cmd_s cmd1_q, cmd1_d, cmd2_q, cmd2_d, wr_cmd;
  logic [sram_pkg::ADDR_W-1:0] base_q, base_d;
  logic [sram_pkg::BURST_W-1:0] cnt_q, cnt_d;
  logic last_valid_q, last_valid_d;
  logic last_write_q, last_write_d;
  logic [sram_pkg::DATA_W-1:0] pipe_q, pipe_d;
  logic pipe_v_q, pipe_v_d;
  logic [sram_pkg::DATA_W-1:0] dq_out_q, dq_out_d;
  logic dq_oe_q, oe_d;
  logic sleep_q, sleep_d;
  logic [sram_pkg::DATA_W-1:0] rd_raw, rd_merged;
  logic wr_en;
  logic [sram_pkg::LANES-1:0] strobes;

  function automatic logic [sram_pkg::BURST_W-1:0] burst_next(
    input logic [sram_pkg::BURST_W-1:0] start,
    input logic [sram_pkg::BURST_W-1:0] idx,
    input logic order
  );
    if (order == sram_pkg::BURST_INTERLEAVE)
    begin
      return start ^ idx;
    end
    return sram_pkg::BURST_W'(start + idx);
  endfunction : burst_next

  // Forward write lanes landing on the address being read in the same edge
  function automatic logic [sram_pkg::DATA_W-1:0] merge_lanes(
    input logic [sram_pkg::DATA_W-1:0] old_data,
    input logic [sram_pkg::DATA_W-1:0] new_data,
    input logic [sram_pkg::LANES-1:0] lanes
  );
    logic [sram_pkg::DATA_W-1:0] res;
    res = old_data;
    for (int i = 0; i < sram_pkg::LANES; i++)
    begin
      if (lanes[i])
      begin
        res[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
          new_data[i*sram_pkg::LANE_W +: sram_pkg::LANE_W];
      end
    end
    return res;
  endfunction : merge_lanes

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'h0;
      rst_sync_q <= 1'h0;
    end
    else
    begin
      rst_meta_q <= 1'h1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign ce = !clock_gate_n; // [R16]
  assign selected = !chip_select_low_1 && chip_select_high && !chip_select_low_3; // [R12] [R14]
  assign strobes = ~{lane_store_d_n, lane_store_c_n, lane_store_b_n, lane_store_a_n}; // [R11]

  // Command capture; a new command may land every edge, read or write alike
  always_comb
  begin
    cmd1_d = sram_pkg::CMD_IDLE;
    base_d = base_q;
    cnt_d = cnt_q;
    last_valid_d = 1'h0;
    last_write_d = last_write_q;
    sleep_d = sleep_request;
    if (sleep_request) // [R13]
    begin
      cmd1_d = sram_pkg::CMD_IDLE;
    end
    else if (burst_step && last_valid_q) // [R15]
    begin
      cnt_d = sram_pkg::BURST_W'(cnt_q + 1'h1);
      cmd1_d.valid = 1'h1;
      cmd1_d.write = last_write_q;
      cmd1_d.lane_we = last_write_q ? strobes : '0;
      cmd1_d.addr = {base_q[sram_pkg::ADDR_W-1:sram_pkg::BURST_W],
                     burst_next(base_q[sram_pkg::BURST_W-1:0], cnt_d, burst_order_select)}; // [R9]
      last_valid_d = 1'h1;
    end
    else if (selected) // [R7] [R1]
    begin
      base_d = addr;
      cnt_d = sram_pkg::BURST_FIRST;
      cmd1_d.valid = 1'h1;
      cmd1_d.write = !write_n; // [R17]
      cmd1_d.lane_we = !write_n ? strobes : '0;
      cmd1_d.addr = addr;
      last_valid_d = 1'h1;
      last_write_d = !write_n;
    end
  end

  // Flow-through writes one edge after the command, pipelined two edges after
  assign wr_cmd = flow_through_select ? cmd1_q : cmd2_q; // [R8] [R6]
  assign wr_en = wr_cmd.valid && wr_cmd.write;

  sram_array #(
    .ADDR_W(sram_pkg::ADDR_W),
    .LANE_W(sram_pkg::LANE_W),
    .LANES(sram_pkg::LANES)
  ) u_array (
    .sys_clk(sys_clk),
    .clk_ok(ce),
    .wr_en(wr_en),
    .lane_we(wr_cmd.lane_we),
    .wr_addr(wr_cmd.addr),
    .wr_data(dq_in),
    .rd_addr(cmd1_q.addr),
    .rd_data(rd_raw)
  );

  // Read data path; mode input is expected static while traffic flows
  always_comb
  begin
    rd_merged = rd_raw;
    if (wr_en && wr_cmd.addr == cmd1_q.addr)
    begin
      rd_merged = merge_lanes(rd_raw, dq_in, wr_cmd.lane_we);
    end
    cmd2_d = cmd1_q;
    pipe_d = rd_merged; // [R5]
    pipe_v_d = cmd1_q.valid && !cmd1_q.write;
    if (flow_through_select) // [R6]
    begin
      dq_out_d = pipe_v_d ? rd_merged : dq_out_q;
      oe_d = pipe_v_d;
    end
    else
    begin
      dq_out_d = pipe_v_q ? pipe_q : dq_out_q; // [R5]
      oe_d = pipe_v_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      cmd1_q <= sram_pkg::CMD_IDLE;
      cmd2_q <= sram_pkg::CMD_IDLE;
      base_q <= '0;
      cnt_q <= sram_pkg::BURST_FIRST;
      last_valid_q <= 1'h0;
      last_write_q <= 1'h0;
      pipe_q <= sram_pkg::DATA_RESET;
      pipe_v_q <= 1'h0;
      dq_out_q <= sram_pkg::DATA_RESET;
      sleep_q <= 1'h0;
    end
    else if (ce) // [R18]
    begin
      cmd1_q <= cmd1_d;
      cmd2_q <= cmd2_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      last_valid_q <= last_valid_d;
      last_write_q <= last_write_d;
      pipe_q <= pipe_d;
      pipe_v_q <= pipe_v_d;
      dq_out_q <= dq_out_d;
      sleep_q <= sleep_d;
    end
  end

  // Driver enable is cleared without the clock; a gated async clear is the price
  assign oe_kill = !rst_sync_q || out_enable_n || sleep_request; // [R2] [R3]

  always_ff @(posedge sys_clk or posedge oe_kill)
  begin
    if (oe_kill) // [R3]
    begin
      dq_oe_q <= 1'h0;
    end
    else if (ce)
    begin
      dq_oe_q <= oe_d;
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign sleep_active = sleep_q;

  a_oe_override: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R3]
    out_enable_n |-> !dq_oe)
    else $error("driver enabled while output enable is off");

  a_sleep_quiet: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R13]
    (ce && sleep_request) |=> (!cmd1_q.valid && sleep_active && !dq_oe))
    else $error("command accepted or drive on during sleep");

  a_select_gate: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R12]
    (ce && !sleep_request && !(burst_step && last_valid_q) && !selected) |=> !cmd1_q.valid)
    else $error("cycle taken without all chip selects");

  a_write_decode: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R17]
    (ce && !sleep_request && !burst_step && selected)
    |=> (cmd1_q.valid && cmd1_q.write == !$past(write_n)))
    else $error("read or write misdecoded");

  a_burst_step: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R15]
    (ce && !sleep_request && burst_step && last_valid_q)
    |=> (cnt_q == 2'($past(cnt_q) + 1'h1) && base_q == $past(base_q)))
    else $error("burst counter did not advance");

  a_burst_order: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R9]
    (ce && !sleep_request && burst_step && last_valid_q && burst_order_select)
    |=> cmd1_q.addr[1:0] == ($past(base_q[1:0]) ^ cnt_q))
    else $error("interleaved burst address wrong");

  a_clock_freeze: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R18]
    !ce |=> ($stable(cmd1_q) && $stable(cnt_q) && $stable(dq_out_q) && $stable(pipe_q)))
    else $error("state moved while clock gate is off");

  a_late_write: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R8]
    (ce && !flow_through_select && !sleep_request && !burst_step && selected && !write_n)
    ##1 ce ##1 (ce && !flow_through_select) |-> wr_en)
    else $error("pipelined write not two cycles behind address");

  a_pipe_read: assert property (@(posedge sys_clk) disable iff (!rst_sync_q) // [R5]
    (ce && !flow_through_select && cmd1_q.valid && !cmd1_q.write) ##1 ce
    |=> dq_out_q == $past(pipe_q))
    else $error("pipelined read data not released from output register");

endmodule : sync_burst_sram_port

// >>> host_model.sv
// Host controller model: late write data timing and strapped burst order
`timescale 1ns/1ns
module host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_gate_n,
  input wire logic flow,
  input wire logic order,
  input wire logic wr_go,
  input wire logic [sram_pkg::DATA_W-1:0] wdata,
  output logic burst_order_select,
  output logic [sram_pkg::DATA_W-1:0] dq_in
);
  logic [1:0] v_q = 2'h0;
  logic [sram_pkg::DATA_W-1:0] d1_q, d2_q;
  logic [sram_pkg::DATA_W-1:0] last_q = '0;
  // Strap may only move while reset holds the port
  always_latch
    if (!rst_n)
      burst_order_select = order;
  // Gated edges do not count toward the data delay
  always @(posedge sys_clk)
    if (!clock_gate_n)
    begin
      v_q <= {v_q[0], wr_go};
      d1_q <= wdata;
      d2_q <= d1_q;
      last_q <= dq_in;
    end
  // Undriven bus toggles so stale data can never pass for a match
  assign dq_in = (flow ? v_q[0] : v_q[1]) ? (flow ? d1_q : d2_q) : ~last_q;
endmodule : host_model

// >>> sync_burst_sram_port_tb.sv
// Self-checking bench for the synchronous burst static RAM port
`timescale 1ns/1ns
module sync_burst_sram_port_tb;
  localparam int W = sram_pkg::DATA_W;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic clock_gate_n = 1'h0;
  logic [sram_pkg::ADDR_W-1:0] addr = '0;
  logic [3:0] lanes_n = 4'hf;
  logic [2:0] cs = 3'h5;
  logic write_n = 1'h1, burst_step = 1'h0, flow = 1'h0, order = 1'h0;
  logic out_enable_n = 1'h0, sleep_request = 1'h0, wr_go = 1'h0;
  logic [W-1:0] wdata = '0;
  logic [W-1:0] dq_in, dq_out, keep;
  logic dq_oe, sleep_active, burst_order_select;
  logic [W-1:0] mem [int];
  logic ev [4];
  logic [W-1:0] ed [4];
  int lat = 2, err_count = 0, checked = 0, cycles = 0;

  always #50 sys_clk = ~sys_clk;

  sync_burst_sram_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .clock_gate_n(clock_gate_n),
    .addr(addr), .write_n(write_n), .lane_store_a_n(lanes_n[0]), .lane_store_b_n(lanes_n[1]),
    .lane_store_c_n(lanes_n[2]), .lane_store_d_n(lanes_n[3]), .chip_select_low_1(cs[0]),
    .chip_select_high(cs[1]), .chip_select_low_3(cs[2]), .burst_step(burst_step),
    .burst_order_select(burst_order_select), .flow_through_select(flow),
    .out_enable_n(out_enable_n), .sleep_request(sleep_request), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .sleep_active(sleep_active));

  host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .clock_gate_n(clock_gate_n),
    .flow(flow), .order(order), .wr_go(wr_go), .wdata(wdata),
    .burst_order_select(burst_order_select), .dq_in(dq_in));

  task automatic chk36(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk36

  task automatic chk1(input string n, input logic e, input logic g);
    chk36(n, {35'h0, e}, {35'h0, g});
  endtask : chk1

  // Every enabled edge moves the read pipe; gated edges must move nothing
  task automatic step();
    @(posedge sys_clk);
    #10;
    if (!clock_gate_n)
    begin
      for (int i = 3; i > 0; i--)
      begin
        ev[i] = ev[i-1];
        ed[i] = ed[i-1];
      end
      ev[0] = 1'h0;
      chk1("dq_oe", ev[lat+1] & !out_enable_n, dq_oe);
      if (ev[lat+1])
        chk36("dq_out", ed[lat+1], dq_out);
    end
  endtask : step

  // Burst cycles drive a wrong address so only the counter can be right
  task automatic cyc(input logic wr, input logic stp, input logic [3:0] ln,
                     input logic [17:0] a, input logic [W-1:0] d);
    write_n = !wr;
    burst_step = stp;
    lanes_n = ln;
    addr = stp ? ~a : a;
    cs = 3'h2;
    wdata = d;
    wr_go = wr;
    ev[0] = !wr;
    ed[0] = wr ? '0 : mem[a];
    for (int i = 0; i < 4; i++)
      if (wr && !ln[i])
        mem[a][i*9+:9] = d[i*9+:9];
    step();
  endtask : cyc

  task automatic idle();
    cs = 3'h5;
    wr_go = 1'h0;
    burst_step = 1'h0;
    step();
  endtask : idle

  function automatic logic [17:0] nb(input logic [17:0] a, input logic [1:0] n);
    nb = {a[17:2], order ? a[1:0] ^ n : a[1:0] + n};
  endfunction : nb

  task automatic phase(input logic f, input logic o);
    logic [17:0] a;
    a = 18'h0105;
    rst_n = 1'h0;
    flow = f;
    order = o;
    lat = f ? 1 : 2;
    foreach (ev[i]) ev[i] = 1'h0;
    repeat (20) @(posedge sys_clk);
    #10 rst_n = 1'h1;
    repeat (3) step();
    chk36("dq_out", sram_pkg::DATA_RESET, dq_out);
    chk1("sleep_active", 1'h0, sleep_active);
    for (int n = 0; n < 4; n++)
      cyc(1'h1, n != 0, 4'h0, nb(a, n[1:0]), 36'h9_0000_0000 + n);
    for (int n = 0; n < 4; n++)
      cyc(1'h0, n != 0, 4'hf, nb(a, n[1:0]), '0);
    cyc(1'h1, 1'h0, 4'ha, a, 36'h5_5555_5555);
    if (!f)
      cyc(1'h0, 1'h0, 4'hf, a, '0);
    cyc(1'h0, 1'h0, 4'hf, nb(a, 2'h1), '0);
    cyc(1'h0, 1'h0, 4'hf, a, '0);
    idle();
    for (int i = 0; i < 4; i++)
    begin
      cs = (i == 3) ? 3'h2 : 3'h2 ^ (3'h1 << i);
      sleep_request = (i == 3);
      write_n = 1'h0;
      lanes_n = 4'h0;
      addr = a;
      step();
    end
    chk1("sleep_active", 1'h1, sleep_active);
    sleep_request = 1'h0;
    idle();
    // Read a word unlike the one on dq_out so a leaky freeze shows up
    cyc(1'h0, 1'h0, 4'hf, nb(a, 2'h1), '0);
    keep = dq_out;
    clock_gate_n = 1'h1;
    repeat (3) step();
    chk36("dq_out", keep, dq_out);
    clock_gate_n = 1'h0;
    repeat (lat) idle();
    out_enable_n = 1'h1;
    #1;
    chk1("dq_oe", 1'h0, dq_oe);
    idle();
    out_enable_n = 1'h0;
  endtask : phase

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Two short phases need about 95 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  initial
  begin
    phase(1'h0, 1'h0);
    phase(1'h1, 1'h1);
    report_and_stop();
  end
endmodule : sync_burst_sram_port_tb
